// >>> ccss_pkg.sv
package ccss_pkg;

  localparam int REF_CLK_HZ = 100_000_000;
  localparam int SLOW_OSC_HZ = 32_768;
  localparam int FAST_OSC_HZ = 4_000_000;
  localparam int SLOW_DIV = REF_CLK_HZ / SLOW_OSC_HZ;
  localparam int FAST_DIV = REF_CLK_HZ / FAST_OSC_HZ;
  localparam int INSTR_CLKS = 2;

  localparam int ADDR_W = 16;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 16'hff00;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 16'hff04;
  localparam int WORD_LSB = 2;

  localparam int SEL_BIT = 3;
  localparam int EN_BIT = 2;
  localparam int VDC_BIT = 0;
  localparam int STAT_FAST_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int STAT_SLOW_BIT = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic cpu_clock_select;
    logic fast_osc_enable;
    logic voltage_select_bit;
  } ccss_ctrl_t;

  localparam ccss_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b0};

  typedef struct packed {
    logic slow_tick;
    logic fast_tick;
  } ccss_osc_t;

endpackage

// >>> ccss_tick_div.sv
`timescale 1ns/100ps
module ccss_tick_div #(
  parameter int DIV = 25
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Control and tick.
  input wire logic i_run,
  output logic o_tick
);
  import ccss_pkg::*;

  localparam int CW = $clog2(DIV) + 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } ccss_div_st_t;

  ccss_div_st_t st_ff;
  ccss_div_st_t nxt_st;

  // A stopped oscillator restarts from a full period, so its first
  // tick after enable is never a short one.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (!i_run) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt == LAST) begin
      nxt_st.cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + CW'(1);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_tick = st_ff.tick;
endmodule

// >>> ccss_clk_switch.sv
`timescale 1ns/100ps
module ccss_clk_switch (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Oscillator ticks and selection.
  input wire ccss_pkg::ccss_osc_t i_osc,
  input wire logic i_sel_fast,
  input wire logic i_fast_run,
  // Gated CPU clock and state.
  output logic o_cpu_tick,
  output logic o_on_fast,
  output logic o_on_slow
);
  import ccss_pkg::*;

  typedef struct packed {
    logic slow_on;
    logic fast_on;
    logic tick;
  } ccss_sw_st_t;

  ccss_sw_st_t st_ff;
  ccss_sw_st_t nxt_st;
  logic want_fast;

  // A stopped fast source is never taken up: the CPU would otherwise
  // drop the slow clock and then wait for ticks that never come.
  assign want_fast = i_sel_fast & i_fast_run;

  // Each source is released on its own tick, or the fast one when it stops,
  // and the other is taken up only on its own tick, so no runt period reaches the CPU.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = (i_osc.slow_tick & st_ff.slow_on) |
                  (i_osc.fast_tick & st_ff.fast_on);
    if (want_fast) begin
      if (st_ff.slow_on && i_osc.slow_tick) begin
        nxt_st.slow_on = 1'b0;
      end
      if (!st_ff.slow_on && !st_ff.fast_on && i_osc.fast_tick) begin
        nxt_st.fast_on = 1'b1;
      end
    end else begin
      if (st_ff.fast_on && i_osc.fast_tick) begin
        nxt_st.fast_on = 1'b0;
      end
      if (!st_ff.slow_on && !st_ff.fast_on && i_osc.slow_tick) begin
        nxt_st.slow_on = 1'b1;
      end
    end
    // A stopped fast oscillator gives no more ticks; drop it so the
    // slow clock can be picked up again instead of stalling forever.
    if (!i_fast_run) begin
      nxt_st.fast_on = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_ff <= '{slow_on: 1'b1, fast_on: 1'b0, tick: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_cpu_tick = st_ff.tick;
  assign o_on_fast = st_ff.fast_on;
  assign o_on_slow = st_ff.slow_on;
endmodule

// >>> ccss_top.sv
`timescale 1ns/100ps
module ccss_top #(
  parameter int SLOW_DIVIDE = ccss_pkg::SLOW_DIV,
  parameter int FAST_DIVIDE = ccss_pkg::FAST_DIV
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // AXI4-Lite write address channel.
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ccss_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  // AXI4-Lite write data channel.
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response channel.
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read address channel.
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ccss_pkg::ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  // AXI4-Lite read data channel.
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Clock enables towards the CPU and the peripherals.
  output logic o_cpu_clk_en,
  output logic o_instr_cycle_en,
  output logic o_fast_clk_en,
  output logic o_slow_clk_en,
  // Oscillator and switch state.
  output logic o_fast_osc_run,
  output logic o_cpu_on_fast
);
  import ccss_pkg::*;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [3:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    ccss_ctrl_t ctrl;
    logic [1:0] instr_cnt;
    logic instr_en;
    logic cpu_en;
    logic fast_en;
    logic slow_en;
    logic on_fast;
  } ccss_top_st_t;

  localparam logic [1:0] INSTR_LAST = 2'(INSTR_CLKS - 1);

  ccss_top_st_t st_ff;
  ccss_top_st_t nxt_st;
  ccss_osc_t osc;
  logic slow_tick;
  logic fast_tick;
  logic cpu_tick;
  logic sw_on_fast;
  logic sw_on_slow;
  logic [3:0] ctrl_word;
  logic [3:0] stat_word;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_ctrl;
  logic wr_stat;
  logic rd_ctrl;
  logic rd_stat;

  ccss_tick_div #(
    .DIV(SLOW_DIVIDE)
  ) u_slow_div (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_run(1'b1),
    .o_tick(slow_tick)
  );

  ccss_tick_div #(
    .DIV(FAST_DIVIDE)
  ) u_fast_div (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_run(st_ff.ctrl.fast_osc_enable),
    .o_tick(fast_tick)
  );

  assign osc = '{slow_tick: slow_tick, fast_tick: fast_tick};

  ccss_clk_switch u_switch (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_osc(osc),
    .i_sel_fast(st_ff.ctrl.cpu_clock_select),
    .i_fast_run(st_ff.ctrl.fast_osc_enable),
    .o_cpu_tick(cpu_tick),
    .o_on_fast(sw_on_fast),
    .o_on_slow(sw_on_slow)
  );

  // Bit 1 is not built, so it always reads back as zero.
  always_comb begin
    ctrl_word = '0;
    ctrl_word[SEL_BIT] = st_ff.ctrl.cpu_clock_select;
    ctrl_word[EN_BIT] = st_ff.ctrl.fast_osc_enable;
    ctrl_word[VDC_BIT] = st_ff.ctrl.voltage_select_bit;
  end

  always_comb begin
    stat_word = '0;
    stat_word[STAT_FAST_BIT] = sw_on_fast;
    stat_word[STAT_RUN_BIT] = st_ff.ctrl.fast_osc_enable;
    stat_word[STAT_SLOW_BIT] = sw_on_slow;
  end

  assign aw_take = i_awvalid & st_ff.awready;
  assign w_take = i_wvalid & st_ff.wready;
  assign ar_take = i_arvalid & st_ff.arready;
  assign wr_ctrl =
    st_ff.aw_addr[ADDR_W-1:WORD_LSB] == CTRL_ADDR[ADDR_W-1:WORD_LSB];
  assign wr_stat =
    st_ff.aw_addr[ADDR_W-1:WORD_LSB] == STAT_ADDR[ADDR_W-1:WORD_LSB];
  assign rd_ctrl =
    i_araddr[ADDR_W-1:WORD_LSB] == CTRL_ADDR[ADDR_W-1:WORD_LSB];
  assign rd_stat =
    i_araddr[ADDR_W-1:WORD_LSB] == STAT_ADDR[ADDR_W-1:WORD_LSB];

  always_comb begin
    nxt_st = st_ff;

    // Address and data are captured independently, in either order.
    if (aw_take) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = i_awaddr;
    end
    if (w_take) begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_data = i_wdata[3:0];
      nxt_st.w_lane0 = i_wstrb[0];
    end

    if (st_ff.bvalid && i_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // The write is done only when both halves are present and the
    // previous response has gone, so one write is in flight at a time.
    if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      if (wr_ctrl) begin
        if (st_ff.w_lane0) begin
          nxt_st.ctrl.fast_osc_enable = st_ff.w_data[EN_BIT];
          nxt_st.ctrl.voltage_select_bit =
            st_ff.w_data[VDC_BIT];
          // The select bit follows the voltage bit in the same write;
          // with that bit clear the CPU stays on the slow clock.
          nxt_st.ctrl.cpu_clock_select =
            st_ff.w_data[SEL_BIT] & st_ff.w_data[VDC_BIT];
        end
      end else if (!wr_stat) begin
        nxt_st.bresp = RESP_SLVERR;
      end
    end

    nxt_st.awready = !nxt_st.aw_held;
    nxt_st.wready = !nxt_st.w_held;

    // Reads answer in the cycle after the address is taken.
    if (st_ff.rvalid && i_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (ar_take) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RESP_OKAY;
      nxt_st.rdata = '0;
      if (rd_ctrl) begin
        nxt_st.rdata[3:0] = ctrl_word;
      end else if (rd_stat) begin
        nxt_st.rdata[3:0] = stat_word;
      end else begin
        nxt_st.rresp = RESP_SLVERR;
      end
    end
    nxt_st.arready = !nxt_st.rvalid;

    // One instruction cycle spans two CPU clock periods on either
    // source, so the rate scales with the selected oscillator.
    nxt_st.instr_en = 1'b0;
    if (cpu_tick) begin
      if (st_ff.instr_cnt == INSTR_LAST) begin
        nxt_st.instr_cnt = '0;
        nxt_st.instr_en = 1'b1;
      end else begin
        nxt_st.instr_cnt = st_ff.instr_cnt + 2'h1;
      end
    end

    nxt_st.cpu_en = cpu_tick;
    nxt_st.fast_en = osc.fast_tick;
    nxt_st.slow_en = osc.slow_tick;
    nxt_st.on_fast = sw_on_fast;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_ff <= '0;
      st_ff.ctrl <= CTRL_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_awready = st_ff.awready;
  assign o_wready = st_ff.wready;
  assign o_bvalid = st_ff.bvalid;
  assign o_bresp = st_ff.bresp;
  assign o_arready = st_ff.arready;
  assign o_rvalid = st_ff.rvalid;
  assign o_rdata = st_ff.rdata;
  assign o_rresp = st_ff.rresp;
  assign o_cpu_clk_en = st_ff.cpu_en;
  assign o_instr_cycle_en = st_ff.instr_en;
  assign o_fast_clk_en = st_ff.fast_en;
  assign o_slow_clk_en = st_ff.slow_en;
  assign o_fast_osc_run = st_ff.ctrl.fast_osc_enable;
  assign o_cpu_on_fast = st_ff.on_fast;
endmodule

// >>> ccss_top_sva.sv
`timescale 1ns/100ps
module ccss_top_sva #(
  parameter int SLOW_DIVIDE = 3051,
  parameter int FAST_DIVIDE = 25
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Watched outputs.
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic o_cpu_clk_en,
  input wire logic o_instr_cycle_en,
  input wire logic o_fast_clk_en,
  input wire logic o_slow_clk_en,
  input wire logic o_fast_osc_run,
  input wire logic o_cpu_on_fast
);
  int cnt_ff;
  logic seen_ff;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // The first slow tick after reset has no reference, so it is skipped.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || o_slow_clk_en) begin
      cnt_ff <= 0;
    end else begin
      cnt_ff <= cnt_ff + 1;
    end
    seen_ff <= !i_rst && (seen_ff || o_slow_clk_en);
  end
  fast_gated_a: assert property (
    o_fast_clk_en |-> $past(o_fast_osc_run)) else $error("fast tick off");
  fast_stop_a: assert property (
    $fell(o_fast_osc_run) |-> ##2 !o_fast_clk_en [*8])
    else $error("fast tick after stop");
  on_fast_a: assert property (
    $rose(o_cpu_on_fast) |-> $past(o_fast_osc_run))
    else $error("switched to a stopped source");
  rdata_hi_a: assert property (
    o_rvalid |-> o_rdata[31:4] == 28'h0) else $error("upper bits set");
  instr_gap_a: assert property (
    o_instr_cycle_en |=> !o_instr_cycle_en [*5])
    else $error("instruction pulses too close");
  slow_per_a: assert property (
    o_slow_clk_en && seen_ff |-> cnt_ff == SLOW_DIVIDE - 1)
    else $error("slow period wrong");
  fast_gap_a: assert property (
    o_fast_clk_en |=> !o_fast_clk_en [*2]) else $error("fast runt");
  cpu_gap_a: assert property (
    o_cpu_clk_en |=> !o_cpu_clk_en [*2]) else $error("cpu runt");
  cover property ($rose(o_cpu_on_fast));
  cover property ($fell(o_cpu_on_fast));
  cover property ($fell(o_fast_osc_run));
endmodule

bind ccss_top ccss_top_sva #(
  .SLOW_DIVIDE(SLOW_DIVIDE),
  .FAST_DIVIDE(FAST_DIVIDE)
) u_sva (.*);

// >>> tb_ccss_top.sv
`timescale 1ns/100ps
module tb_ccss_top;
  import ccss_pkg::*;
  localparam int SD = 12;
  localparam int FD = 3;
  logic i_ref_clk = 0, i_rst = 1;
  logic i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  logic i_arvalid = 0, i_rready = 0;
  logic [15:0] i_awaddr = '0, i_araddr = '0;
  logic [2:0] i_awprot = '0, i_arprot = '0;
  logic [31:0] i_wdata = '0, rd;
  logic [3:0] i_wstrb = 4'hf;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp, rs;
  logic [31:0] o_rdata;
  logic o_cpu_clk_en, o_instr_cycle_en, o_fast_clk_en, o_slow_clk_en;
  logic o_fast_osc_run, o_cpu_on_fast;
  int fail_count = 0, cmp_count = 0, cyc = 0, n;

  ccss_top #(.SLOW_DIVIDE(SD), .FAST_DIVIDE(FD)) u_dut (.*);

  always #5 i_ref_clk = ~i_ref_clk;

  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict;
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Response ready is held from the start, as the bus allows.
  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_awaddr <= a;
    i_wdata <= d;
    i_bready <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid);
    rs = o_bresp;
    i_bready <= 1'b0;
  endtask

  task rdr(input logic [15:0] a);
    @(posedge i_ref_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      if (o_arready) i_arvalid <= 1'b0;
    end while (!o_rvalid);
    rd = o_rdata;
    rs = o_rresp;
    i_rready <= 1'b0;
  endtask

  function automatic logic pick(input int k);
    logic [3:0] v;
    v = {o_slow_clk_en, o_fast_clk_en, o_instr_cycle_en, o_cpu_clk_en};
    return v[k];
  endfunction

  // Cycles between two pulses: 0 cpu, 1 instruction, 2 fast, 3 slow.
  task per(input int k);
    do @(posedge i_ref_clk); while (!pick(k));
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (!pick(k));
  endtask

  task t_reset;
    rdr(CTRL_ADDR);
    chk(rd, 32'h0);
    per(0);
    chk(n, SD);
    per(1);
    chk(n, 2 * SD);
    per(3);
    chk(n, SD);
    $display("reset test done");
  endtask

  task t_gate;
    wr(CTRL_ADDR, 32'h4);
    repeat (60) @(posedge i_ref_clk);
    chk(o_fast_osc_run, 1'b1);
    per(2);
    chk(n, FD);
    wr(CTRL_ADDR, 32'hc);
    rdr(CTRL_ADDR);
    chk(rd, 32'h4);
    repeat (40) @(posedge i_ref_clk);
    chk(o_cpu_on_fast, 1'b0);
    $display("gate test done");
  endtask

  task t_fast;
    wr(CTRL_ADDR, 32'hf);
    rdr(CTRL_ADDR);
    chk(rd, 32'hd);
    repeat (40) @(posedge i_ref_clk);
    chk(o_cpu_on_fast, 1'b1);
    per(0);
    chk(n, FD);
    per(1);
    chk(n, 2 * FD);
    rdr(STAT_ADDR);
    chk(rd, 32'h3);
    $display("fast test done");
  endtask

  task t_back;
    wr(CTRL_ADDR, 32'h5);
    repeat (40) @(posedge i_ref_clk);
    chk(o_cpu_on_fast, 1'b0);
    per(0);
    chk(n, SD);
    wr(CTRL_ADDR, 32'h0);
    rdr(STAT_ADDR);
    chk(rd, 32'h4);
    $display("back test done");
  endtask

  // A write whose lowest byte lane is off must leave control untouched.
  task t_unmap;
    wr(16'h0010, 32'hf);
    chk(rs, RESP_SLVERR);
    rdr(16'h0010);
    chk({rd[1:0], rs}, {2'h0, RESP_SLVERR});
    i_wstrb <= 4'he;
    wr(CTRL_ADDR, 32'hf);
    i_wstrb <= 4'hf;
    chk(rs, RESP_OKAY);
    rdr(CTRL_ADDR);
    chk(rd, 32'h0);
    $display("unmapped test done");
  endtask

  // Select set with the fast source stopped must keep the CPU on slow.
  task t_stall;
    wr(CTRL_ADDR, 32'h9);
    rdr(CTRL_ADDR);
    chk(rd, 32'h9);
    repeat (40) @(posedge i_ref_clk);
    chk(o_cpu_on_fast, 1'b0);
    per(0);
    chk(n, SD);
    wr(CTRL_ADDR, 32'h0);
    rdr(STAT_ADDR);
    chk(rd, 32'h4);
    $display("stall test done");
  endtask

  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    t_reset;
    t_gate;
    t_fast;
    t_back;
    t_unmap;
    t_stall;
    print_verdict;
  end
endmodule
